/* File: adcc_pkg.sv */
// Purpose: Shared constants and carriers for the converter core control.
// Assumes: Byte addresses on a 32-bit Avalon-MM bus, 16-bit registers.
// Notes: Registers sit in the low half of each word; the upper half is 0.

package adcc_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [5:0] OFS_WARM_CTRL = 6'h00;
    localparam logic [5:0] OFS_DELAY0 = 6'h04;
    localparam logic [5:0] OFS_DELAY1 = 6'h08;
    localparam logic [5:0] OFS_CFG0 = 6'h0C;
    localparam logic [5:0] OFS_CFG1 = 6'h10;
    localparam logic [5:0] OFS_LEVEL = 6'h14;
    localparam logic [5:0] OFS_EARLY_EN = 6'h18;
    localparam logic [5:0] OFS_EARLY_ST = 6'h1C;
    localparam logic [5:0] OFS_POWER = 6'h20;
    localparam logic [5:0] OFS_AUX = 6'h24;
    localparam logic [5:0] OFS_IRQ_ST = 6'h28;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h2C;

    // ------------------------------------------------------------------
    // Writable bit masks and reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] MSK_WARM_CTRL = 16'h0F83;
    localparam logic [15:0] MSK_DELAY = 16'h03FF;
    localparam logic [15:0] MSK_CFG = 16'h1F7F;
    localparam logic [15:0] MSK_CHAN = 16'h7FFF;
    localparam logic [15:0] MSK_POWER = 16'h0083;
    localparam logic [15:0] MSK_AUX = 16'h3F03;
    localparam logic [15:0] MSK_IRQ = 16'h000F;
    localparam logic [15:0] RST_CFG = 16'h0300;
    localparam logic [15:0] RST_IRQ_MASK = 16'h000F;
    localparam logic [15:0] RST_ZERO = 16'h0000;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned WARM_LSB = 8;
    localparam int unsigned SHR_BIT = 7;
    localparam int unsigned RDY_LSB = 8;
    localparam int unsigned SHR_RDY_BIT = 15;
    localparam int unsigned SRCDIV_LSB = 8;
    localparam int unsigned IRQ_SHR = 2;
    localparam int unsigned IRQ_EARLY = 3;
    localparam logic [3:0] WARM_MIN_CODE = 4'h4;

    // ------------------------------------------------------------------
    // Conversion timing in per-core clocks
    // ------------------------------------------------------------------
    localparam logic [9:0] CONV_BASE = 10'h007; // 6-bit length minus one.

    typedef enum logic [1:0] {
        CST_IDLE = 2'b00,
        CST_DELAY = 2'b01,
        CST_CONV = 2'b11
    } adcc_cstate_t;

    typedef struct packed {
        logic [2:0] early_lead_select;
        logic [1:0] resolution_select;
        logic conv_delay_enable;
        logic [9:0] conv_delay_code;
    } adcc_core_cfg_t;

    typedef struct packed {
        logic sampling;
        logic converting;
        logic early;
        logic done;
    } adcc_core_stat_t;

endpackage : adcc_pkg

/* File: adcc_tick.sv */
// Purpose: Strobe divider, one tick every lim+1 steps.
// Assumes: step is a same-clock strobe.
// Notes: Disabled divider restarts from zero.

module adcc_tick #(
    parameter int unsigned W = 8
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Control.
    input wire logic en,
    input wire logic step,
    input wire logic [W-1:0] lim,
    // Result.
    output logic tick
);

    logic [W-1:0] cnt_q;

    // Tick on the step that completes a period.
    assign tick = en && step && (cnt_q >= lim);

    // Count steps; a lowered limit never strands the counter above it.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else if (!en) begin
            cnt_q <= '0;
        end else if (step) begin
            cnt_q <= (cnt_q >= lim) ? '0 : cnt_q + 1'b1;
        end
    end

endmodule : adcc_tick

/* File: adcc_core.sv */
// Purpose: Sequencer for one dedicated converter core.
// Assumes: core_tick is one strobe per per-core clock period.
// Notes: Conversion takes resolution bits plus two per-core clocks.

module adcc_core (
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Settings and timing.
    input wire adcc_pkg::adcc_core_cfg_t cfg,
    input wire logic core_tick,
    input wire logic ready,
    input wire logic trig,
    // State seen by the analog core.
    output adcc_pkg::adcc_core_stat_t stat
);

    adcc_pkg::adcc_cstate_t st_q;
    logic [9:0] cnt_q;
    logic dly_q;
    logic [9:0] conv_last;

    // 6, 8, 10 or 12 bits by resolution code.
    assign conv_last = adcc_pkg::CONV_BASE
        + {7'h00, cfg.resolution_select, 1'b0};

    // Sampling runs while idle and through an enabled delay only.
    always_comb begin
        stat.sampling = (st_q == adcc_pkg::CST_IDLE)
            || ((st_q == adcc_pkg::CST_DELAY) && dly_q);
        stat.converting = (st_q == adcc_pkg::CST_CONV);
        stat.early = stat.converting && core_tick
            && (cnt_q == {6'h00, 1'b0, cfg.early_lead_select}
            + 10'h001);
        stat.done = stat.converting && core_tick && (cnt_q == 10'h000);
    end

    // Delay counts code+1 more ticks after the first, so conversion starts code+2
    // per-core clocks after the trigger, except code 3FF, which wraps and takes 1.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_q <= adcc_pkg::CST_IDLE;
            cnt_q <= 10'h000;
            dly_q <= 1'b0;
        end else if (!ready) begin
            st_q <= adcc_pkg::CST_IDLE;
        end else begin
            case (st_q)
                adcc_pkg::CST_IDLE: begin
                    if (trig) begin
                        st_q <= adcc_pkg::CST_DELAY;
                        dly_q <= cfg.conv_delay_enable;
                        cnt_q <= cfg.conv_delay_enable
                            ? cfg.conv_delay_code + 10'h001
                            : 10'h000;
                    end
                end
                adcc_pkg::CST_DELAY: begin
                    if (core_tick) begin
                        if (cnt_q == 10'h000) begin
                            st_q <= adcc_pkg::CST_CONV;
                            cnt_q <= conv_last;
                        end else begin
                            cnt_q <= cnt_q - 10'h001;
                        end
                    end
                end
                adcc_pkg::CST_CONV: begin
                    if (core_tick) begin
                        if (cnt_q == 10'h000) begin
                            st_q <= adcc_pkg::CST_IDLE;
                        end else begin
                            cnt_q <= cnt_q - 10'h001;
                        end
                    end
                end
                default: begin
                    st_q <= adcc_pkg::CST_IDLE;
                end
            endcase
        end
    end

endmodule : adcc_core

/* File: adcc_top.sv */
// Purpose: Warm-up, ready interrupts, dedicated core timing, triggers.
// Assumes: Avalon-MM slave, trig_in asynchronous, other inputs same clock.
// Notes: Index 2 of the core vectors is the shared core.

module adcc_top #(
    parameter int unsigned NCH = 15,
    parameter int unsigned CORE0_CHAN = 0,
    parameter int unsigned CORE1_CHAN = 1
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Avalon-MM slave.
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Channel triggers and neighbour events.
    input wire logic [NCH-1:0] trig_in,
    input wire logic [NCH-1:0] shared_early_in,
    input wire logic [NCH-1:0] result_read,
    // Analog core control.
    output logic [2:0] core_power,
    output logic [2:0] core_ready,
    output logic [3:0] core_res,
    output logic [1:0] core_sampling,
    output logic [1:0] core_converting,
    output logic [1:0] core_data_ready,
    output logic [NCH-1:0] early_pulse,
    output logic irq
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic wait_q;
    logic take;
    logic wr_en;
    logic [15:0] wdat;
    logic [15:0] warm_q;
    logic [15:0] delay_q [2];
    logic [15:0] cfg_q [2];
    logic [15:0] lvl_q;
    logic [15:0] eie_q;
    logic [15:0] est_q;
    logic [15:0] pwr_q;
    logic [15:0] aux_q;
    logic [15:0] ist_q;
    logic [15:0] imask_q;
    logic [15:0] rd_mux;
    localparam logic [15:0] RST_ZERO_W = adcc_pkg::RST_ZERO;

    // Merge the written low half under its byte enables.
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] msk);
        logic [15:0] be;
        be = {{8{byteenable[1]}}, {8{byteenable[0]}}} & msk;
        merge = (old & ~be) | (writedata[15:0] & be);
    endfunction : merge

    // One wait cycle per access: the request is taken while waitrequest
    // is high and answered with waitrequest low on the next cycle.
    assign take = (read || write) && wait_q;
    assign wr_en = write && wait_q;
    assign wdat = writedata[15:0] & {{8{byteenable[1]}},
                                     {8{byteenable[0]}}};
    assign waitrequest = wait_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !take;
        end
    end

    // Plain read/write control registers.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            warm_q <= RST_ZERO_W;
            delay_q[0] <= RST_ZERO_W;
            delay_q[1] <= RST_ZERO_W;
            cfg_q[0] <= adcc_pkg::RST_CFG;
            cfg_q[1] <= adcc_pkg::RST_CFG;
            lvl_q <= RST_ZERO_W;
            eie_q <= RST_ZERO_W;
            pwr_q <= RST_ZERO_W;
            aux_q <= RST_ZERO_W;
            imask_q <= adcc_pkg::RST_IRQ_MASK;
        end else if (wr_en) begin
            case (address)
                adcc_pkg::OFS_WARM_CTRL:
                    warm_q <= merge(warm_q, adcc_pkg::MSK_WARM_CTRL);
                adcc_pkg::OFS_DELAY0:
                    delay_q[0] <= merge(delay_q[0], adcc_pkg::MSK_DELAY);
                adcc_pkg::OFS_DELAY1:
                    delay_q[1] <= merge(delay_q[1], adcc_pkg::MSK_DELAY);
                adcc_pkg::OFS_CFG0:
                    cfg_q[0] <= merge(cfg_q[0], adcc_pkg::MSK_CFG);
                adcc_pkg::OFS_CFG1:
                    cfg_q[1] <= merge(cfg_q[1], adcc_pkg::MSK_CFG);
                adcc_pkg::OFS_LEVEL:
                    lvl_q <= merge(lvl_q, adcc_pkg::MSK_CHAN);
                adcc_pkg::OFS_EARLY_EN:
                    eie_q <= merge(eie_q, adcc_pkg::MSK_CHAN);
                adcc_pkg::OFS_POWER:
                    pwr_q <= merge(pwr_q, adcc_pkg::MSK_POWER);
                adcc_pkg::OFS_AUX:
                    aux_q <= merge(aux_q, adcc_pkg::MSK_AUX);
                adcc_pkg::OFS_IRQ_MASK:
                    imask_q <= merge(imask_q, adcc_pkg::MSK_IRQ);
                default: begin
                end
            endcase
        end
    end


    // ------------------------------------------------------------------
    // Clock strobes
    // ------------------------------------------------------------------
    logic src_tick;
    logic [1:0] core_tick;
    logic [2:0] pwr_vec;

    assign pwr_vec = {pwr_q[adcc_pkg::SHR_BIT], pwr_q[1:0]};

    // Source clock: module clock over divider code plus one.
    adcc_tick #(.W(6)) u_src_div (
        .clock(clock),
        .rstn(rstn),
        .en(1'b1),
        .step(1'b1),
        .lim(aux_q[adcc_pkg::SRCDIV_LSB +: 6]),
        .tick(src_tick)
    );

    // ------------------------------------------------------------------
    // Warm-up and ready flags, shared core at index 2
    // ------------------------------------------------------------------
    logic [3:0] warm_exp;
    logic [15:0] warm_last;
    logic [2:0] rdy_q;
    logic [2:0] rdy_prev_q;
    logic [2:0] rdy_rise;

    // Codes below the minimum all give 16 source periods.
    assign warm_exp = (warm_q[adcc_pkg::WARM_LSB +: 4]
        < adcc_pkg::WARM_MIN_CODE) ? adcc_pkg::WARM_MIN_CODE
        : warm_q[adcc_pkg::WARM_LSB +: 4];
    assign warm_last = 16'((17'h00001 << warm_exp) - 17'h00001);
    assign rdy_rise = rdy_q & ~rdy_prev_q;

    for (genvar g = 0; g < 3; g++) begin : g_warm
        logic [15:0] wcnt_q;

        // Power-off drops ready at once and restarts warm-up.
        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                wcnt_q <= 16'h0000;
                rdy_q[g] <= 1'b0;
            end else if (!pwr_vec[g]) begin
                wcnt_q <= 16'h0000;
                rdy_q[g] <= 1'b0;
            end else if (!rdy_q[g] && src_tick) begin
                if (wcnt_q >= warm_last) begin
                    rdy_q[g] <= 1'b1;
                end else begin
                    wcnt_q <= wcnt_q + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdy_prev_q <= 3'h0;
        end else begin
            rdy_prev_q <= rdy_q;
        end
    end

    // ------------------------------------------------------------------
    // Trigger qualification
    // ------------------------------------------------------------------
    logic [NCH-1:0] trg_s1_q;
    logic [NCH-1:0] trg_s2_q;
    logic [NCH-1:0] trg_s3_q;
    logic [NCH-1:0] trg_req;

    // Two flops before use; the third only feeds edge detection.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            trg_s1_q <= '0;
            trg_s2_q <= '0;
            trg_s3_q <= '0;
        end else begin
            trg_s1_q <= trig_in;
            trg_s2_q <= trg_s1_q;
            trg_s3_q <= trg_s2_q;
        end
    end

    // A held level retriggers each time the core returns to idle.
    assign trg_req = (lvl_q[NCH-1:0] & trg_s2_q)
        | (~lvl_q[NCH-1:0] & trg_s2_q & ~trg_s3_q);

    // ------------------------------------------------------------------
    // Dedicated cores
    // ------------------------------------------------------------------
    adcc_pkg::adcc_core_stat_t stat [2];
    logic [1:0] core_trig;

    assign core_trig = {trg_req[CORE1_CHAN], trg_req[CORE0_CHAN]};

    for (genvar c = 0; c < 2; c++) begin : g_core
        adcc_pkg::adcc_core_cfg_t ccfg;
        logic [6:0] dcode;
        logic [7:0] dlim;

        assign dcode = cfg_q[c][6:0];
        // Period is twice the code; codes 0 and 1 both give 2.
        assign dlim = ((dcode < 7'h02) ? 8'h02 : {dcode, 1'b0})
            - 8'h01;
        assign ccfg.early_lead_select = cfg_q[c][12:10];
        assign ccfg.resolution_select = cfg_q[c][9:8];
        assign ccfg.conv_delay_enable = aux_q[c];
        assign ccfg.conv_delay_code = delay_q[c][9:0];

        adcc_tick #(.W(8)) u_core_div (
            .clock(clock),
            .rstn(rstn),
            .en(pwr_vec[c]),
            .step(src_tick),
            .lim(dlim),
            .tick(core_tick[c])
        );

        adcc_core u_core (
            .clock(clock),
            .rstn(rstn),
            .cfg(ccfg),
            .core_tick(core_tick[c]),
            .ready(rdy_q[c]),
            .trig(core_trig[c]),
            .stat(stat[c])
        );
    end

    // ------------------------------------------------------------------
    // Early interrupts per channel
    // ------------------------------------------------------------------
    logic [NCH-1:0] early_evt;
    logic [NCH-1:0] est_clr;

    for (genvar i = 0; i < NCH; i++) begin : g_early
        assign early_evt[i] = eie_q[i] && (shared_early_in[i]
            || (i == CORE0_CHAN && stat[0].early)
            || (i == CORE1_CHAN && stat[1].early));
    end

    assign est_clr = result_read | ((wr_en
        && address == adcc_pkg::OFS_EARLY_ST) ? wdat[NCH-1:0] : '0);

    // A new event in the clearing cycle wins over the clear.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            est_q <= RST_ZERO_W;
        end else begin
            est_q[NCH-1:0] <= (est_q[NCH-1:0] & ~est_clr)
                | early_evt;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status, mask and output
    // ------------------------------------------------------------------
    logic [15:0] ist_set;
    logic [15:0] ist_clr;

    assign ist_set = {12'h000, |early_evt,
        rdy_rise[2] && warm_q[adcc_pkg::SHR_BIT],
        rdy_rise[1:0] & warm_q[1:0]};
    assign ist_clr = (wr_en && address == adcc_pkg::OFS_IRQ_ST)
        ? wdat & adcc_pkg::MSK_IRQ : 16'h0000;

    // Sticky bits, write one to clear; a set in the same cycle wins.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ist_q <= RST_ZERO_W;
            irq <= 1'b0;
        end else begin
            ist_q <= (ist_q & ~ist_clr) | ist_set;
            irq <= |(ist_q & imask_q);
        end
    end

    // ------------------------------------------------------------------
    // Read path and registered core outputs
    // ------------------------------------------------------------------
    always_comb begin
        case (address)
            adcc_pkg::OFS_WARM_CTRL: rd_mux = warm_q;
            adcc_pkg::OFS_DELAY0: rd_mux = delay_q[0];
            adcc_pkg::OFS_DELAY1: rd_mux = delay_q[1];
            adcc_pkg::OFS_CFG0: rd_mux = cfg_q[0];
            adcc_pkg::OFS_CFG1: rd_mux = cfg_q[1];
            adcc_pkg::OFS_LEVEL: rd_mux = lvl_q;
            adcc_pkg::OFS_EARLY_EN: rd_mux = eie_q;
            adcc_pkg::OFS_EARLY_ST: rd_mux = est_q;
            adcc_pkg::OFS_POWER: rd_mux = pwr_q
                | {rdy_q[2], 5'h00, rdy_q[1:0], 8'h00};
            adcc_pkg::OFS_AUX: rd_mux = aux_q;
            adcc_pkg::OFS_IRQ_ST: rd_mux = ist_q;
            adcc_pkg::OFS_IRQ_MASK: rd_mux = imask_q;
            default: rd_mux = 16'h0000;
        endcase
    end

    // Read data is captured as the request is taken and held after.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            readdata <= 32'h0000_0000;
        end else if (take && read) begin
            readdata <= {16'h0000, rd_mux};
        end
    end

    // Core-facing outputs, one cycle behind the sequencers.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            core_sampling <= 2'h0;
            core_converting <= 2'h0;
            core_data_ready <= 2'h0;
            core_ready <= 3'h0;
            early_pulse <= '0;
        end else begin
            core_sampling <= {stat[1].sampling, stat[0].sampling};
            core_converting <= {stat[1].converting, stat[0].converting};
            core_data_ready <= {stat[1].done, stat[0].done};
            core_ready <= rdy_q;
            early_pulse <= early_evt;
        end
    end

    assign core_power = pwr_vec;
    assign core_res = {cfg_q[1][9:8], cfg_q[0][9:8]};

endmodule : adcc_top

/* File: adcc_top_monitor.sv */
// Purpose: Concurrent checks on the converter control top ports.
// Assumes: Single clock, asynchronous active-low reset.
// Notes: Bound into every adcc_top instance.
module adcc_mon #(
    parameter int unsigned NCH = 15
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Bus handshake.
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    // Core state and events.
    input wire logic [2:0] core_power,
    input wire logic [2:0] core_ready,
    input wire logic [3:0] core_res,
    input wire logic [1:0] core_sampling,
    input wire logic [1:0] core_converting,
    input wire logic [1:0] core_data_ready,
    input wire logic [NCH-1:0] shared_early_in,
    input wire logic [NCH-1:0] early_pulse
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // A taken request is answered for exactly one cycle.
    sequence s_req; (read || write) && waitrequest; endsequence
    sequence s_ans; !waitrequest ##1 waitrequest; endsequence
    // Data follows an early pulse soon.
    sequence s_done_soon; ##[1:64] core_data_ready[0]; endsequence
    chk_bus_answer: assert property (s_req |=> s_ans)
        else $error("Bus answer not one cycle.");
    chk_ready_power: assert property (
        core_ready[0] |-> $past(core_power[0], 2))
        else $error("Ready unpowered.");
    chk_warm_min: assert property (
        $rose(core_ready[0]) |-> $past(core_power[0], 16))
        else $error("Warm-up too short.");
    chk_res_reset: assert property (
        $rose(rstn) |-> core_res == 4'hF) else $error("Resolution reset.");
    chk_sample_excl: assert property (
        (core_sampling & core_converting) == 2'h0)
        else $error("Sampling while converting.");
    chk_early_lead: assert property (
        early_pulse[0] |-> s_done_soon) else $error("Early without data.");
    chk_early_only: assert property (
        |early_pulse[NCH-1:2] |-> $past(|shared_early_in[NCH-1:2]))
        else $error("Stray early.");
    chk_done_conv: assert property (
        core_data_ready[0] |-> $past(core_converting[0]))
        else $error("Done without conversion.");
endmodule : adcc_mon

bind adcc_top adcc_mon #(.NCH(NCH)) mon_u (.*);

/* File: adcc_far.sv */
// Purpose: Far-side stand-in for triggers and shared core events.
// Assumes: Commands come from the bench by task call.
// Notes: Triggers are held levels; events are one-clock pulses.
module adcc_far (
    // Clock.
    input wire logic clock,
    // Lines into the block.
    output logic [14:0] trig_in,
    output logic [14:0] shared_early_in,
    output logic [14:0] result_read
);
    // Quiet at time zero so nothing fires on reset release.
    initial begin
        trig_in = '0;
        shared_early_in = '0;
        result_read = '0;
    end
    // Trigger levels change just after an edge.
    task set_trig(input logic [14:0] v);
        @(posedge clock);
        trig_in <= v;
    endtask : set_trig
    // One-clock pulse: an early event, or a result buffer read.
    task pulse(input int ch, input bit rd);
        @(posedge clock);
        if (rd) result_read[ch] <= 1'b1;
        else shared_early_in[ch] <= 1'b1;
        @(posedge clock);
        result_read <= '0;
        shared_early_in <= '0;
    endtask : pulse
endmodule : adcc_far

/* File: adcc_top_tb.sv */
// Purpose: Self-checking bench for the converter core control.
// Assumes: Avalon-MM master at 250 MHz, far side in adcc_far.
// Notes: Dividers stay small so conversions last tens of clocks.
module adcc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rstn, read, write, waitrequest, irq;
    logic [5:0] address;
    logic [31:0] writedata, readdata;
    logic [3:0] byteenable, core_res;
    logic [14:0] trig_in, shared_early_in, result_read, early_pulse;
    logic [2:0] core_power, core_ready;
    logic [1:0] core_sampling, core_converting, core_data_ready;
    int err_total = 0, checks = 0, dcnt = 0, ecnt = 0, lead_m, latoff, lat0;
    int lat, len, samp;
    adcc_top dut_u (.*);
    adcc_far far_u (.*);
    // Free-running 4 ns clock.
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Early-to-data clocks and conversion count.
    always @(posedge clock) begin
        ecnt <= early_pulse[0] ? 0 : ecnt + 1;
        if (core_data_ready[0] === 1'b1) begin
            lead_m <= ecnt + 1;
            dcnt <= dcnt + 1;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    // One bus access; held until waitrequest is seen low at an edge.
    // A read expects d back; a write sends d.
    task automatic acc(input logic [5:0] a, input logic w,
        input logic [15:0] d);
        int n = 0;
        @(posedge clock);
        address <= a;
        read <= !w;
        write <= w;
        writedata <= {16'h0000, d};
        do begin
            @(negedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) err_total++;
        if (!w) chk(readdata, {16'h0000, d});
        @(posedge clock);
        read <= 1'b0;
        write <= 1'b0;
    endtask : acc
    // Trigger core 0; time delay and conversion.
    task automatic conv(input logic [15:0] cfg, input logic [15:0] dly);
        acc(adcc_pkg::OFS_CFG0, 1'b1, cfg);
        acc(adcc_pkg::OFS_DELAY0, 1'b1, dly);
        lat = 0;
        len = 0;
        samp = 0;
        far_u.set_trig(15'h0001);
        while (core_converting[0] !== 1'b1 && lat < 4000) begin
            @(negedge clock);
            lat++;
            samp += (core_sampling[0] === 1'b1);
        end
        while (core_converting[0] === 1'b1 && len < 4000) begin
            @(negedge clock);
            len++;
        end
        far_u.set_trig(15'h0000);
        repeat (4) @(posedge clock);
    endtask : conv
    task results;
        $display("Checks %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results
    // Watchdog well beyond the expected run length.
    initial begin
        #200000;
        err_total++;
        results;
    end
    // Main sequence of tests.
    initial begin
        rstn = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = '0;
        writedata = '0;
        byteenable = 4'hF;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        acc(adcc_pkg::OFS_CFG0, 1'b0, 16'h0300);
        acc(adcc_pkg::OFS_IRQ_MASK, 1'b0, 16'h000F);
        acc(6'h30, 1'b0, 16'h0000);
        acc(adcc_pkg::OFS_WARM_CTRL, 1'b1, 16'h0081);
        acc(adcc_pkg::OFS_POWER, 1'b1, 16'h0083);
        repeat (8) @(negedge clock);
        chk(core_ready, 3'h0);
        repeat (40) @(negedge clock);
        chk(core_ready, 3'h7);
        chk(irq, 1'b1);
        acc(adcc_pkg::OFS_IRQ_ST, 1'b0, 16'h0005);
        acc(adcc_pkg::OFS_POWER, 1'b0, 16'h8383);
        acc(adcc_pkg::OFS_IRQ_MASK, 1'b1, 16'h0000);
        repeat (3) @(negedge clock);
        chk(irq, 1'b0);
        acc(adcc_pkg::OFS_IRQ_MASK, 1'b1, 16'h000F);
        acc(adcc_pkg::OFS_IRQ_ST, 1'b1, 16'h000F);
        repeat (8) @(negedge clock);
        chk(irq, 1'b0);
        $display("Test warm-up and ready done");
        acc(adcc_pkg::OFS_EARLY_EN, 1'b1, 16'h0001);
        conv(16'h0000, 16'h0000);
        latoff = lat;
        acc(adcc_pkg::OFS_EARLY_ST, 1'b0, 16'h0001);
        far_u.pulse(0, 1'b1);
        acc(adcc_pkg::OFS_EARLY_ST, 1'b0, 16'h0000);
        // Leads only as long as each resolution allows.
        for (int i = 0; i < 8; i++) begin
            int r, p;
            r = (i < 4) ? i : 3;
            p = 2 * (((i % 3) == 0) ? 1 : (i % 3));
            conv({3'h0, 3'(i), 2'(r), 1'b0, 7'(i % 3)}, 16'h0000);
            chk(len inside {[(8 + 2 * r) * p - 1:(8 + 2 * r) * p + 1]}, 1);
            chk(lead_m, (i + 1) * p);
        end
        $display("Test resolution and lead done");
        acc(adcc_pkg::OFS_AUX, 1'b1, 16'h0001);
        conv(16'h0000, 16'h0000);
        lat0 = lat;
        conv(16'h0000, 16'h0005);
        chk(samp >= 10, 1);
        chk((lat - lat0) inside {[9:11]}, 1);
        chk((lat0 - latoff) inside {[1:3]}, 1);
        acc(adcc_pkg::OFS_AUX, 1'b1, 16'h0000);
        for (int k = 0; k < 2; k++) begin
            int n0;
            acc(adcc_pkg::OFS_LEVEL, 1'b1, 16'(1 - k));
            n0 = dcnt;
            far_u.set_trig(15'h0001);
            repeat (120) @(negedge clock);
            far_u.set_trig(15'h0000);
            repeat (40) @(negedge clock);
            chk((k == 0) ? (dcnt - n0 >= 3) : (dcnt - n0 == 1), 1);
        end
        $display("Test delay and trigger mode done");
        acc(adcc_pkg::OFS_EARLY_ST, 1'b1, 16'h7FFF);
        acc(adcc_pkg::OFS_IRQ_ST, 1'b1, 16'h000F);
        acc(adcc_pkg::OFS_EARLY_EN, 1'b1, 16'h0000);
        far_u.pulse(5, 1'b0);
        acc(adcc_pkg::OFS_EARLY_ST, 1'b0, 16'h0000);
        acc(adcc_pkg::OFS_EARLY_EN, 1'b1, 16'h0020);
        far_u.pulse(5, 1'b0);
        acc(adcc_pkg::OFS_EARLY_ST, 1'b0, 16'h0020);
        acc(adcc_pkg::OFS_IRQ_ST, 1'b0, 16'h0008);
        $display("Test early enables done");
        results;
    end
endmodule : adcc_top_tb
